// ---- rtl/amsi_pkg.sv ----
/*
  Shared constants for the add-on mailbox status and interrupt block:
  register offsets, field positions, reset values and select codes.
  Assumes a 32-bit add-on register bus with byte offsets.
*/
package amsi_pkg;

  localparam int AW = 8;
  localparam int DW = 32;
  localparam int BYTES = 4;
  localparam int CODE_W = 8;

  localparam logic [AW-1:0] OFS_IN_MBX = 8'h0C;
  localparam logic [AW-1:0] OFS_OUT_MBX = 8'h1C;
  localparam logic [AW-1:0] OFS_FILL = 8'h34;
  localparam logic [AW-1:0] OFS_IRQ = 8'h38;
  localparam logic [AW-1:0] OFS_RST_CTL = 8'h3C;

  localparam int FILL_OUT_LSB = 28;
  localparam int FILL_IN_LSB = 12;

  localparam int IRQ_ANY = 23;
  localparam int IRQ_BIST = 20;
  localparam int IRQ_OUT = 17;
  localparam int IRQ_IN = 16;
  localparam int EN_OUT = 12;
  localparam int HW1_HI_LSB = 10;
  localparam int SEL_OUT_LSB = 8;
  localparam int EN_IN = 4;
  localparam int HW1_LO_LSB = 2;
  localparam int SEL_IN_LSB = 0;

  localparam int LANE_IN_CTL = 0;
  localparam int LANE_OUT_CTL = 1;
  localparam int LANE_IRQ = 2;
  localparam int LANE_CODE = 0;
  localparam int CODE_LSB = 0;

  localparam int SRC_N = 3;
  localparam int SRC_IN = 0;
  localparam int SRC_OUT = 1;
  localparam int SRC_BIST = 2;

  localparam logic [DW-1:0] FILL_RST = 32'h00000000;
  localparam logic [DW-1:0] IRQ_RST = 32'h00000C0C;
  localparam logic [1:0] HW1_VAL = 2'h3;

  typedef enum logic [1:0] {
    SEL_B0 = 2'h0,
    SEL_B1 = 2'h1,
    SEL_B2 = 2'h2,
    SEL_B3 = 2'h3
  } amsi_sel_t;

endpackage

// ---- rtl/amsi_flag_if.sv ----
/*
  Carrier for a vector of sticky flags: set and clear requests in,
  current flag state out.
  Assumes one clock for keeper and user.
*/
`timescale 1ns/1ps
interface amsi_flag_if #(
  parameter int N = 4
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;

  modport keeper (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// ---- rtl/amsi_sticky.sv ----
/*
  Vector of sticky flags; a set in the same cycle as a clear wins.
  Assumes set and clear requests are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module amsi_sticky #(
  parameter int N = 4,
  parameter logic [N-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  amsi_flag_if.keeper f
);
  logic [N-1:0] q_reg;

  assign f.q = q_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= f.set | (q_reg & ~f.clr);
    end
  end
endmodule

// ---- rtl/amsi_byte_pick.sv ----
/*
  Picks one byte lane out of an access mask and gates it with an enable.
  Assumes the mask is a one-cycle access strobe per byte.
*/
`timescale 1ns/1ps
module amsi_byte_pick #(
  parameter int BYTES = 4
) (
  input wire logic [BYTES-1:0] hit,
  input wire logic en,
  input wire amsi_pkg::amsi_sel_t sel,
  output logic trig
);
  import amsi_pkg::*;

  always_comb begin
    case (sel)
      SEL_B0: trig = en & hit[0];
      SEL_B1: trig = en & hit[1];
      SEL_B2: trig = en & hit[2];
      SEL_B3: trig = en & hit[3];
      default: trig = 1'b0;
    endcase
  end
endmodule

// ---- rtl/amsi_mbx_irq.sv ----
/*
  Add-on side mailbox fill status and interrupt control/status registers.
  Assumes PCI-side strobes and the add-on register bus run on clk.
*/
`timescale 1ns/1ps
module amsi_mbx_irq (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [amsi_pkg::AW-1:0] addon_addr,
  input wire logic [amsi_pkg::BYTES-1:0] addon_be,
  input wire logic addon_wr,
  input wire logic addon_rd,
  input wire logic [amsi_pkg::DW-1:0] addon_wdata,
  output logic [amsi_pkg::DW-1:0] addon_rdata,
  input wire logic pci_in_mbx_wr,
  input wire logic [amsi_pkg::BYTES-1:0] pci_in_mbx_be,
  input wire logic pci_out_mbx_rd,
  input wire logic [amsi_pkg::BYTES-1:0] pci_out_mbx_be,
  input wire logic pci_bist_wr,
  output logic [amsi_pkg::DW-1:0] host_view_fill_status,
  output logic addon_irq,
  output logic [amsi_pkg::CODE_W-1:0] bist_code,
  output logic bist_code_wr
);
  import amsi_pkg::*;

  function automatic logic hit(input logic strobe, input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  logic in_mbx_rd;
  logic out_mbx_wr;
  logic irq_wr;
  logic code_wr;

  logic en_in_reg;
  logic en_out_reg;
  amsi_sel_t sel_in_reg;
  amsi_sel_t sel_out_reg;
  logic [DW-1:0] rdata_reg;
  logic [CODE_W-1:0] code_reg;
  logic code_wr_reg;

  logic trig_in;
  logic trig_out;
  logic [DW-1:0] fill_word;
  logic [DW-1:0] irq_word;

  amsi_flag_if #(.N(BYTES)) in_f ();
  amsi_flag_if #(.N(BYTES)) out_f ();
  amsi_flag_if #(.N(SRC_N)) src_f ();

  assign in_mbx_rd = hit(addon_rd, addon_addr, OFS_IN_MBX);
  assign out_mbx_wr = hit(addon_wr, addon_addr, OFS_OUT_MBX);
  assign irq_wr = hit(addon_wr, addon_addr, OFS_IRQ);
  assign code_wr = hit(addon_wr, addon_addr, OFS_RST_CTL);

  // set by writer, cleared by reader
  assign in_f.set = pci_in_mbx_wr ? pci_in_mbx_be : '0;
  assign in_f.clr = in_mbx_rd ? addon_be : '0;

  assign out_f.set = out_mbx_wr ? addon_be : '0;
  assign out_f.clr = pci_out_mbx_rd ? pci_out_mbx_be : '0;

  amsi_sticky #(
    .N(BYTES),
    .RST_VAL(FILL_RST[FILL_IN_LSB +: BYTES])
  ) u_in_flags (
    .clk(clk),
    .rst_b(rst_b),
    .f(in_f)
  );

  amsi_sticky #(
    .N(BYTES),
    .RST_VAL(FILL_RST[FILL_OUT_LSB +: BYTES])
  ) u_out_flags (
    .clk(clk),
    .rst_b(rst_b),
    .f(out_f)
  );

  amsi_byte_pick #(.BYTES(BYTES)) u_pick_in (
    .hit(pci_in_mbx_wr ? pci_in_mbx_be : '0),
    .en(en_in_reg),
    .sel(sel_in_reg),
    .trig(trig_in)
  );

  amsi_byte_pick #(.BYTES(BYTES)) u_pick_out (
    .hit(pci_out_mbx_rd ? pci_out_mbx_be : '0),
    .en(en_out_reg),
    .sel(sel_out_reg),
    .trig(trig_out)
  );

  always_comb begin
    src_f.set = '0;
    src_f.set[SRC_IN] = trig_in;
    src_f.set[SRC_OUT] = trig_out;
    src_f.set[SRC_BIST] = pci_bist_wr;
  end

  always_comb begin
    src_f.clr = '0;
    if (irq_wr && addon_be[LANE_IRQ]) begin
      src_f.clr[SRC_IN] = addon_wdata[IRQ_IN];
      src_f.clr[SRC_OUT] = addon_wdata[IRQ_OUT];
      src_f.clr[SRC_BIST] = addon_wdata[IRQ_BIST];
    end
  end

  amsi_sticky #(
    .N(SRC_N),
    .RST_VAL({IRQ_RST[IRQ_BIST], IRQ_RST[IRQ_OUT], IRQ_RST[IRQ_IN]})
  ) u_src (
    .clk(clk),
    .rst_b(rst_b),
    .f(src_f)
  );

  // incoming enable and byte select
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_in_reg <= IRQ_RST[EN_IN];
      sel_in_reg <= amsi_sel_t'(IRQ_RST[SEL_IN_LSB +: 2]);
    end else if (irq_wr && addon_be[LANE_IN_CTL]) begin
      en_in_reg <= addon_wdata[EN_IN];
      sel_in_reg <= amsi_sel_t'(addon_wdata[SEL_IN_LSB +: 2]);
    end
  end

  // outgoing enable and byte select
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      en_out_reg <= IRQ_RST[EN_OUT];
      sel_out_reg <= amsi_sel_t'(IRQ_RST[SEL_OUT_LSB +: 2]);
    end else if (irq_wr && addon_be[LANE_OUT_CTL]) begin
      en_out_reg <= addon_wdata[EN_OUT];
      sel_out_reg <= amsi_sel_t'(addon_wdata[SEL_OUT_LSB +: 2]);
    end
  end

  // fill status word
  always_comb begin
    fill_word = '0;
    fill_word[FILL_OUT_LSB +: BYTES] = out_f.q;
    fill_word[FILL_IN_LSB +: BYTES] = in_f.q;
  end

  // interrupt control/status word
  always_comb begin
    irq_word = '0;
    irq_word[HW1_HI_LSB +: 2] = HW1_VAL;
    irq_word[HW1_LO_LSB +: 2] = HW1_VAL;
    // summary bit is OR of sources
    irq_word[IRQ_ANY] = |src_f.q;
    irq_word[IRQ_BIST] = src_f.q[SRC_BIST];
    irq_word[IRQ_OUT] = src_f.q[SRC_OUT];
    irq_word[IRQ_IN] = src_f.q[SRC_IN];
    irq_word[EN_OUT] = en_out_reg;
    irq_word[SEL_OUT_LSB +: 2] = sel_out_reg;
    irq_word[EN_IN] = en_in_reg;
    irq_word[SEL_IN_LSB +: 2] = sel_in_reg;
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (addon_rd) begin
      case (addon_addr)
        OFS_FILL: rdata_reg <= fill_word;
        OFS_IRQ: rdata_reg <= irq_word;
        default: rdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_reg <= '0;
      code_wr_reg <= 1'b0;
    end else begin
      code_wr_reg <= code_wr && addon_be[LANE_CODE];
      if (code_wr && addon_be[LANE_CODE]) begin
        code_reg <= addon_wdata[CODE_LSB +: CODE_W];
      end
    end
  end

  assign addon_rdata = rdata_reg;
  assign host_view_fill_status = fill_word;
  assign bist_code = code_reg;
  assign bist_code_wr = code_wr_reg;

  assign addon_irq = |src_f.q;

endmodule

// ---- verification/amsi_properties.sv ----
/*
  Checker for amsi_mbx_irq, watching its ports only.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module amsi_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addon_addr,
  input wire logic [3:0] addon_be,
  input wire logic addon_wr,
  input wire logic addon_rd,
  input wire logic [31:0] addon_wdata,
  input wire logic [31:0] addon_rdata,
  input wire logic pci_in_mbx_wr,
  input wire logic [3:0] pci_in_mbx_be,
  input wire logic pci_out_mbx_rd,
  input wire logic [3:0] pci_out_mbx_be,
  input wire logic pci_bist_wr,
  input wire logic [31:0] host_view_fill_status,
  input wire logic addon_irq,
  input wire logic [7:0] bist_code,
  input wire logic bist_code_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire [3:0] f_in = host_view_fill_status[15:12];
  wire [3:0] f_out = host_view_fill_status[31:28];
  wire ev = pci_in_mbx_wr | pci_out_mbx_rd | pci_bist_wr;
  wire out_wr = addon_wr && addon_addr == 8'h1C;
  wire ack = addon_wr && addon_addr == 8'h38 && addon_be[2];
  sequence s_code;
    addon_wr && addon_addr == 8'h3C && addon_be[0];
  endsequence
  a_in_full: assert property (
    pci_in_mbx_wr |=> (f_in & $past(pci_in_mbx_be)) == $past(pci_in_mbx_be))
    else $error("incoming flag not set");
  a_out_empty: assert property (
    pci_out_mbx_rd && !out_wr |=> (f_out & $past(pci_out_mbx_be)) == 4'h0)
    else $error("outgoing flag not cleared");
  a_irq_cause: assert property ($rose(addon_irq) |-> $past(ev))
    else $error("irq without event");
  a_bist_irq: assert property (pci_bist_wr |=> addon_irq)
    else $error("self-test irq missing");
  a_irq_hold: assert property (addon_irq && !ack |=> addon_irq)
    else $error("irq dropped");
  a_code_ret: assert property (
    s_code |=> bist_code_wr && bist_code == $past(addon_wdata[7:0]))
    else $error("code not returned");
  a_fill_read: assert property (
    addon_rd && addon_addr == 8'h34 |=> addon_rdata == $past(host_view_fill_status))
    else $error("fill read wrong");
  a_ctl_fixed: assert property (addon_rd && addon_addr == 8'h38 |=>
    addon_rdata[31:24] == 8'h00 && addon_rdata[11:10] == 2'h3 &&
    addon_rdata[3:2] == 2'h3 && addon_rdata[23] == $past(addon_irq))
    else $error("control read wrong");
  a_rd_quiet: assert property (
    addon_rd && addon_addr == 8'h1C && !addon_wr && !ev |=>
    $stable(host_view_fill_status) && $stable(addon_irq))
    else $error("outgoing read had effect");
endmodule
bind amsi_mbx_irq amsi_properties u_prop (.clk, .rst_b, .addon_addr, .addon_be,
  .addon_wr, .addon_rd, .addon_wdata, .addon_rdata, .pci_in_mbx_wr, .pci_in_mbx_be,
  .pci_out_mbx_rd, .pci_out_mbx_be, .pci_bist_wr, .host_view_fill_status,
  .addon_irq, .bist_code, .bist_code_wr);

// ---- verification/amsi_pci_host.sv ----
/*
  Host-side model: one-cycle mailbox and self-test event pulses.
  Assumes the caller is in step with clk.
*/
`timescale 1ns/1ps
module amsi_pci_host (
  input wire logic clk,
  output logic pci_in_mbx_wr,
  output logic [3:0] pci_in_mbx_be,
  output logic pci_out_mbx_rd,
  output logic [3:0] pci_out_mbx_be,
  output logic pci_bist_wr
);
  initial begin
    pci_in_mbx_wr = 1'b0;
    pci_out_mbx_rd = 1'b0;
    pci_bist_wr = 1'b0;
    pci_in_mbx_be = 4'h0;
    pci_out_mbx_be = 4'h0;
  end
  task ev(input int k, input logic [3:0] be);
    @(posedge clk);
    #1;
    pci_in_mbx_wr = (k == 0);
    pci_out_mbx_rd = (k == 1);
    pci_bist_wr = (k == 2);
    pci_in_mbx_be = be;
    pci_out_mbx_be = be;
    @(posedge clk);
    #1;
    pci_in_mbx_wr = 1'b0;
    pci_out_mbx_rd = 1'b0;
    pci_bist_wr = 1'b0;
    pci_in_mbx_be = ~be;
    pci_out_mbx_be = ~be;
  endtask
endmodule

// ---- verification/amsi_mbx_irq_tb.sv ----
/*
  Self-checking bench for amsi_mbx_irq.
  Assumes the checker is bound and the host model drives events.
*/
`timescale 1ns/1ps
module amsi_mbx_irq_tb;
  logic clk, rst_b, addon_wr, addon_rd, pci_in_mbx_wr, pci_out_mbx_rd, pci_bist_wr;
  logic addon_irq, bist_code_wr;
  logic [7:0] addon_addr, bist_code;
  logic [3:0] addon_be, pci_in_mbx_be, pci_out_mbx_be, b;
  logic [31:0] addon_wdata, addon_rdata, host_view_fill_status, v;
  int failures = 0, check_count = 0, cyc = 0;
  amsi_pci_host h (.clk, .pci_in_mbx_wr, .pci_in_mbx_be, .pci_out_mbx_rd,
    .pci_out_mbx_be, .pci_bist_wr);
  amsi_mbx_irq DUT (.clk, .rst_b, .addon_addr, .addon_be, .addon_wr, .addon_rd,
    .addon_wdata, .addon_rdata, .pci_in_mbx_wr, .pci_in_mbx_be, .pci_out_mbx_rd,
    .pci_out_mbx_be, .pci_bist_wr, .host_view_fill_status, .addon_irq, .bist_code,
    .bist_code_wr);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    addon_addr = a;
    addon_be = be;
    addon_wdata = d;
    addon_wr = 1'b1;
    @(posedge clk);
    #1;
    addon_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    addon_addr = a;
    addon_be = 4'hF;
    addon_rd = 1'b1;
    @(posedge clk);
    #1;
    addon_rd = 1'b0;
    v = addon_rdata;
  endtask
  task t_reset;
    chk("rdata", 0, addon_rdata);
    rd(8'h34);
    chk("fill", 0, v);
    rd(8'h38);
    chk("ctl", 32'h00000C0C, v);
    rd(8'h00);
    chk("unmapped", 0, v);
    $display("t_reset done");
  endtask
  task t_in;
    for (int s = 0; s < 4; s++) begin
      b = 4'h1 << s;
      wr(8'h38, 4'h1, 32'h10 | s);
      h.ev(0, ~b);
      chk("irq", 0, addon_irq);
      chk("fill", {16'h0, ~b, 12'h0}, host_view_fill_status);
      h.ev(0, b);
      chk("irq", 1, addon_irq);
      rd(8'h38);
      chk("ctl", 32'h00810C1C | s, v);
      wr(8'h38, 4'h4, 0);
      chk("irq", 1, addon_irq);
      wr(8'h38, 4'h4, 32'h10000);
      chk("irq", 0, addon_irq);
      rd(8'h0C);
      chk("fill", 0, host_view_fill_status);
    end
    $display("t_in done");
  endtask
  task t_out;
    for (int s = 0; s < 4; s++) begin
      b = 4'h1 << s;
      wr(8'h38, 4'h2, 32'h1000 | (s << 8));
      wr(8'h1C, b, 0);
      chk("fill", {b, 28'h0}, host_view_fill_status);
      rd(8'h1C);
      chk("fill", {b, 28'h0}, host_view_fill_status);
      h.ev(1, ~b);
      chk("irq", 0, addon_irq);
      h.ev(1, b);
      chk("irq", 1, addon_irq);
      chk("fill", 0, host_view_fill_status);
      wr(8'h38, 4'h4, 32'h20000);
      wr(8'h38, 4'h2, 0);
      h.ev(1, 4'hF);
      chk("irq", 0, addon_irq);
    end
    $display("t_out done");
  endtask
  task t_bist;
    h.ev(2, 4'h0);
    rd(8'h38);
    chk("ctl", 32'h00900C1F, v);
    wr(8'h38, 4'h4, 32'h100000);
    chk("irq", 0, addon_irq);
    fork
      h.ev(2, 4'h0);
      wr(8'h38, 4'h4, 32'h100000);
    join
    chk("irq", 1, addon_irq);
    wr(8'h38, 4'h4, 32'h100000);
    chk("irq", 0, addon_irq);
    wr(8'h38, 4'hC, 32'hFF6C0000);
    rd(8'h38);
    chk("ctl", 32'h00000C1F, v);
    wr(8'h3C, 4'h1, 32'hA5);
    chk("code", 32'hA5, bist_code);
    chk("pulse", 1, bist_code_wr);
    @(posedge clk);
    #1;
    chk("pulse", 0, bist_code_wr);
    $display("t_bist done");
  endtask
  task t_rst_mid;
    h.ev(0, 4'hF);
    wr(8'h1C, 4'h3, 0);
    chk("irq", 1, addon_irq);
    chk("fill", 32'h3000F000, host_view_fill_status);
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk("irq", 0, addon_irq);
    chk("fill", 0, host_view_fill_status);
    chk("code", 0, bist_code);
    chk("rdata", 0, addon_rdata);
    rd(8'h38);
    chk("ctl", 32'h00000C0C, v);
    $display("t_rst_mid done");
  endtask
  initial begin
    rst_b = 1'b0;
    addon_wr = 1'b0;
    addon_rd = 1'b0;
    addon_addr = 8'h00;
    addon_be = 4'h0;
    addon_wdata = 32'h0;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_in();
    t_out();
    t_bist();
    t_rst_mid();
    end_sim();
  end
endmodule
